// [tb/serial_peer.sv]
// Behavioural synchronous serial peer on the clock and data lines
`timescale 1ns/10ps
module serial_peer
(
  input  wire logic       ck_line,
  input  wire logic       dt_line,
  output logic            peer_ck,
  output logic            peer_dt
);
  logic [8:0] rx_word;
  initial
  begin
    peer_ck = 1'b0;
    peer_dt = 1'b1;
    rx_word = 9'h000;
  end
  // ********
  // Frame transfer, LSB first
  // ********
  task automatic xfer(input logic [8:0] w, input int n, input logic slave);
    for (int i = 0; i < n; i++)
    begin
      peer_dt = w[i];
      if (slave)
      begin
        // Clock runs only inside frames, 64 ns period
        peer_ck = 1'b1;
        #32;
        rx_word[i] = dt_line;
        peer_ck = 1'b0;
        #32;
      end
      else
      begin
        @(negedge ck_line);
        rx_word[i] = dt_line;
        if (i < n - 1)
          @(posedge ck_line);
      end
    end
    // Released line must not keep a stale level
    peer_dt = ~peer_dt;
  endtask : xfer
endmodule : serial_peer

// [tb/sync_serial_properties.sv]
// Pin and bus checks for the synchronous serial port
`timescale 1ns/10ps
module sync_serial_properties
(
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        ck_in,
  input wire logic        ck_out,
  input wire logic        ck_oe,
  input wire logic        dt_in,
  input wire logic        dt_out,
  input wire logic        dt_oe,
  input wire logic        irq_req
);
  // ********
  // Checks
  // ********
  logic rd_ap;
  logic wr_ap;
  assign rd_ap = hsel && htrans[1] && hready && !hwrite;
  assign wr_ap = hsel && htrans[1] && hready && hwrite;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  read_hold_a: assert property (!$past(rd_ap) |-> $stable(hrdata))
    else $error("read data moved without a read");
  reset_quiet_a: assert property (disable iff (1'b0) !nrst |=> !ck_oe && !dt_oe && !irq_req)
    else $error("pins active after reset");
  // Divisor 3 gives four cycles a half period; a shorter one means the divisor is ignored
  master_clock_a: assert property (ck_oe && $changed(ck_out) |=> (!ck_oe || $stable(ck_out))[*3])
    else $error("shift clock half period too short");
  half_duplex_a: assert property (ck_oe |-> !dt_oe)
    else $error("data driven during master reception");
  tx_start_a: assert property ($rose(dt_oe) |-> $past(wr_ap, 2) || $past(wr_ap, 3) || $past(wr_ap, 4))
    else $error("transmit started without a buffer write");
  tx_hold_a: assert property ($rose(dt_oe) |-> dt_oe[*8])
    else $error("data drive dropped early");
  cover property ($rose(ck_oe));
  cover property ($fell(dt_oe));
  cover property ($rose(irq_req));
endmodule : sync_serial_properties

bind sync_serial_receive_and_slave sync_serial_properties u_sync_serial_properties (
  .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .ck_in(ck_in), .ck_out(ck_out), .ck_oe(ck_oe),
  .dt_in(dt_in), .dt_out(dt_out), .dt_oe(dt_oe), .irq_req(irq_req));

// [tb/test_sync_serial_receive_and_slave.sv]
// Self-checking bench for the synchronous serial port
`timescale 1ns/10ps
`include "sync_serial_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_sync_serial_receive_and_slave;
  logic        sys_clk, nrst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        ck_in, ck_out, ck_oe, dt_in, dt_out, dt_oe, irq_req, peer_ck, peer_dt;
  int          bad_count, checks;
  // ********
  // Wiring: resolved lines feed every party
  // ********
  assign hready = hreadyout;
  assign ck_in = ck_oe ? ck_out : peer_ck;
  assign dt_in = dt_oe ? dt_out : peer_dt;
  sync_serial_receive_and_slave u_sync_serial_receive_and_slave (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ck_in(ck_in), .ck_out(ck_out), .ck_oe(ck_oe),
    .dt_in(dt_in), .dt_out(dt_out), .dt_oe(dt_oe), .irq_req(irq_req));
  serial_peer u_serial_peer (.ck_line(ck_in), .dt_line(dt_in), .peer_ck(peer_ck),
    .peer_dt(peer_dt));
  always #2.5 sys_clk = ~sys_clk;
  // ********
  // Bus and wait helpers
  // ********
  task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {27'h0, idx, 2'b00};
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input string nm, input logic [2:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK(nm, e, rd)
  endtask : rdc
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (irq_req !== lvl && n < 3000);
    `CHK("irq_req", lvl, irq_req)
    @(posedge sys_clk);
  endtask : wait_irq
  task automatic idle_chk(input string nm, input logic e, input int cyc);
    repeat (cyc) @(negedge sys_clk);
    `CHK(nm, e, ck_out)
    @(posedge sys_clk);
  endtask : idle_chk
  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    rdc("rx status", `RX_STATUS_CONTROL_IDX, `CONTROL_RESET);
    rdc("baud", `BAUD_CONTROL_IDX, `CONTROL_RESET);
    rdc("div high", `BAUD_DIV_HIGH_IDX, `DIVISOR_RESET);
    bus(1'b1, `BAUD_DIV_LOW_IDX, 8'hA5);
    rdc("div low", `BAUD_DIV_LOW_IDX, 8'hA5);
    bus(1'b1, `RX_BUFFER_IDX, 8'h3C);
    rdc("rx buffer", `RX_BUFFER_IDX, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_master_single(input logic pol, input logic [7:0] w);
    bus(1'b1, `BAUD_DIV_LOW_IDX, 8'h03);
    bus(1'b1, `BAUD_CONTROL_IDX, {3'h0, pol, 4'h0});
    bus(1'b1, `IRQ_CONTROL_IDX, 8'h01);
    bus(1'b1, `TX_STATUS_CONTROL_IDX, 8'h90);
    bus(1'b1, `RX_STATUS_CONTROL_IDX, 8'h80);
    idle_chk("clock before enable", pol, 20);
    `CHK("clock drive", 1'b1, ck_oe)
    fork
      u_serial_peer.xfer({1'b0, w}, 8, 1'b0);
      bus(1'b1, `RX_STATUS_CONTROL_IDX, 8'hA0);
    join
    wait_irq(1'b1);
    rdc("single cleared", `RX_STATUS_CONTROL_IDX, 8'h80);
    rdc("word", `RX_BUFFER_IDX, w);
    wait_irq(1'b0);
    idle_chk("clock after word", pol, 40);
    bus(1'b1, `RX_STATUS_CONTROL_IDX, 8'h00);
    $display("test master single done");
  endtask : t_master_single
  task automatic t_master_cont;
    logic [8:0] w[4] = '{9'h1A5, 9'h03C, 9'h15A, 9'h0C3};
    bus(1'b1, `RX_STATUS_CONTROL_IDX, 8'hC0);
    fork
      for (int i = 0; i < 4; i++) u_serial_peer.xfer(w[i], 9, 1'b0);
      begin
        bus(1'b1, `RX_STATUS_CONTROL_IDX, 8'hF0);
        for (int i = 0; i < 2; i++)
        begin
          wait_irq(1'b1);
          bus(1'b0, `RX_STATUS_CONTROL_IDX, 8'h00);
          `CHK("rx status", 8'hD0 | w[i][8], rd & 32'hDF)
          rdc("word", `RX_BUFFER_IDX, w[i][7:0]);
        end
      end
    join
    @(posedge sys_clk);
    bus(1'b0, `RX_STATUS_CONTROL_IDX, 8'h00);
    `CHK("overrun", 8'h12, rd & 32'h12)
    rdc("kept word", `RX_BUFFER_IDX, w[2][7:0]);
    bus(1'b1, `RX_STATUS_CONTROL_IDX, 8'hC0);
    bus(1'b0, `RX_STATUS_CONTROL_IDX, 8'h00);
    `CHK("overrun cleared", 8'h00, rd & 32'h02)
    bus(1'b1, `RX_STATUS_CONTROL_IDX, 8'h00);
    $display("test master continuous done");
  endtask : t_master_cont
  task automatic t_slave_rx;
    bus(1'b1, `TX_STATUS_CONTROL_IDX, 8'h10);
    bus(1'b1, `RX_STATUS_CONTROL_IDX, 8'hA0);
    u_serial_peer.xfer(9'h05B, 8, 1'b1);
    repeat (10) @(negedge sys_clk);
    `CHK("single ignored", 1'b0, irq_req)
    `CHK("clock input", 1'b0, ck_oe)
    @(posedge sys_clk);
    bus(1'b1, `RX_STATUS_CONTROL_IDX, 8'h90);
    u_serial_peer.xfer(9'h0B5, 8, 1'b1);
    wait_irq(1'b1);
    rdc("slave word", `RX_BUFFER_IDX, 8'hB5);
    bus(1'b1, `RX_STATUS_CONTROL_IDX, 8'h80);
    $display("test slave receive done");
  endtask : t_slave_rx
  task automatic t_slave_tx;
    bus(1'b1, `IRQ_CONTROL_IDX, 8'h02);
    bus(1'b1, `TX_STATUS_CONTROL_IDX, 8'h30);
    bus(1'b1, `TX_BUFFER_IDX, 8'h3C);
    bus(1'b1, `TX_BUFFER_IDX, 8'hC3);
    rdc("tx flag clear", `IRQ_CONTROL_IDX, 8'h02);
    u_serial_peer.xfer(9'h000, 8, 1'b1);
    `CHK("first word", 8'h3C, u_serial_peer.rx_word[7:0])
    wait_irq(1'b1);
    rdc("tx flag set", `IRQ_CONTROL_IDX, 8'h0A);
    u_serial_peer.xfer(9'h000, 8, 1'b1);
    `CHK("second word", 8'hC3, u_serial_peer.rx_word[7:0])
    repeat (10) @(negedge sys_clk);
    `CHK("data released", 1'b0, dt_oe)
    @(posedge sys_clk);
    $display("test slave transmit done");
  endtask : t_slave_tx
  task automatic summarize;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    {sys_clk, nrst, hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    bad_count = 0;
    checks = 0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_master_single(1'b0, 8'hA5);
    t_master_single(1'b1, 8'h3C);
    t_master_cont;
    t_slave_rx;
    t_slave_tx;
    summarize;
  end
  // Whole run needs about 1100 cycles; 12000 means a hang
  initial
  begin
    #60000;
    bad_count++;
    summarize;
  end
endmodule : test_sync_serial_receive_and_slave

// [verilog/sync_serial_pkg.sv]
// Types shared by the synchronous serial port
package sync_serial_pkg;

  typedef enum logic [1:0] {IDLE, RECV, SEND} mode_t;

  typedef struct packed {
    logic        ck_s1;
    logic        ck_s2;
    logic        ck_s3;
    logic        dt_s1;
    logic        dt_s2;
    logic        ph_valid;
    logic        ph_write;
    logic [2:0]  ph_idx;
    logic [31:0] rdata;
    logic        port_enable;
    logic        nine_bit_rx_option;
    logic        single_word_rx_enable;
    logic        continuous_rx_enable;
    logic        overrun_error;
    logic        received_ninth_bit;
    logic        clock_source_select;
    logic        nine_bit_tx_option;
    logic        transmit_enable;
    logic        sync_mode;
    logic        transmit_ninth_bit;
    logic        clock_idle_polarity;
    logic        sixteen_bit_divisor_option;
    logic [7:0]  div_high;
    logic [7:0]  div_low;
    logic        receive_irq_enable;
    logic        transmit_irq_enable;
    logic [7:0]  rx_buf;
    logic        rx_full;
    logic [8:0]  tx_buf;
    logic        tx_full;
    logic [8:0]  transmit_shift_register;
    logic [8:0]  receive_shift_register;
    mode_t       mode;
    logic [3:0]  bit_cnt;
    logic        shift_owed;
    logic [15:0] baud_cnt;
    logic        clk_lvl;
    logic        dt_drive;
  } state_t;

endpackage : sync_serial_pkg

// [verilog/sync_serial_receive_and_slave.sv]
// Synchronous serial port: master/slave reception, slave transmission, AHB-Lite registers
`timescale 1ns/10ps
`include "sync_serial_regs.svh"

module sync_serial_receive_and_slave
  import sync_serial_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ck_in,
  output logic             ck_out,
  output logic             ck_oe,
  input  wire logic        dt_in,
  output logic             dt_out,
  output logic             dt_oe,
  output logic             irq_req
);

  // ****************************************************************
  // State and helpers
  // ****************************************************************
  state_t      s;
  state_t      n;
  logic        enabled;
  logic        master;
  logic        rx_go;
  logic [15:0] divisor;
  logic        tick;
  logic        m_toggle;
  logic        rise;
  logic        fall;
  logic [3:0]  nbits;
  logic [3:0]  cnt_inc;
  logic [8:0]  word;
  logic        addr_ok;
  logic [7:0]  rd_val;

  // ****************************************************************
  // Bus answers
  // ****************************************************************
  // Zero wait states; every access completes OKAY, only haddr[4:2] is decoded so every read hits a register
  // Size is not decoded: only whole-word accesses are expected
  assign hrdata    = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************************************
  // Pins and wake request
  // ****************************************************************
  assign ck_out  = s.clk_lvl;
  // Slave never drives the clock; the peer owns the line then
  assign ck_oe   = enabled & master;
  assign dt_out  = s.dt_drive;
  assign dt_oe   = enabled & (s.mode == SEND);
  assign irq_req = (s.receive_irq_enable & s.rx_full)
                 | (s.transmit_irq_enable & ~s.tx_full);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // One combinational pass builds the whole next state; the only
  // register stage is the single always_ff at the bottom
  always_comb
  begin
    n = s;

    // ****************************************************************
    // Pin synchronisers and mode decode
    // ****************************************************************
    // Synchronisers; stage three only exists for edge detection on clean stage two
    n.ck_s1 = ck_in;
    n.ck_s2 = s.ck_s1;
    n.ck_s3 = s.ck_s2;
    n.dt_s1 = dt_in;
    n.dt_s2 = s.dt_s1;

    enabled = s.port_enable & s.sync_mode;
    master  = s.clock_source_select;
    rx_go   = s.continuous_rx_enable | (s.single_word_rx_enable & master);
    // A divisor of zero toggles every cycle, the fastest shift clock
    divisor = s.sixteen_bit_divisor_option ? {s.div_high, s.div_low} : {8'h00, s.div_low};
    tick    = (s.baud_cnt == divisor);

    // ****************************************************************
    // Shift clock generation and edge detection
    // ****************************************************************
    // Master clock parks at its idle level between words
    m_toggle = master & enabled & tick & ((s.mode != IDLE) | (s.clk_lvl != s.clock_idle_polarity));
    if (master & enabled)
    begin
      rise = m_toggle & ~s.clk_lvl;
      fall = m_toggle & s.clk_lvl;
    end
    else
    begin
      // peer clock paces the shifter; no divider involved
      rise = enabled & s.ck_s2 & ~s.ck_s3;
      fall = enabled & ~s.ck_s2 & s.ck_s3;
    end
    if (!(master & enabled) || ((s.mode == IDLE) && (s.clk_lvl == s.clock_idle_polarity)))
      n.baud_cnt = 16'h0000;
    else if (tick)
      n.baud_cnt = 16'h0000;
    else
      n.baud_cnt = s.baud_cnt + 16'h0001;
    // Disabled or slave: the clock output parks at the idle level
    if (!(master & enabled))
      n.clk_lvl = s.clock_idle_polarity;
    else if (m_toggle)
      n.clk_lvl = ~s.clk_lvl;

    // ****************************************************************
    // Register reads and writes
    // ****************************************************************
    // Only NONSEQ or SEQ with ready high opens an address phase
    addr_ok = hsel & htrans[1] & hready;
    n.ph_valid = addr_ok;
    n.ph_write = hwrite;
    n.ph_idx   = haddr[4:2];
    // Read data is registered, so it stands for the whole data phase
    case (haddr[4:2])
      `RX_STATUS_CONTROL_IDX: rd_val = {s.port_enable, s.nine_bit_rx_option,
                                        s.single_word_rx_enable, s.continuous_rx_enable,
                                        2'b00, s.overrun_error, s.received_ninth_bit};
      `RX_BUFFER_IDX:         rd_val = s.rx_buf;
      `TX_STATUS_CONTROL_IDX: rd_val = {s.clock_source_select, s.nine_bit_tx_option,
                                        s.transmit_enable, s.sync_mode, 2'b00,
                                        s.mode != SEND, s.transmit_ninth_bit};
      `BAUD_CONTROL_IDX:      rd_val = {3'b000, s.clock_idle_polarity,
                                        s.sixteen_bit_divisor_option, 3'b000};
      `BAUD_DIV_HIGH_IDX:     rd_val = s.div_high;
      `BAUD_DIV_LOW_IDX:      rd_val = s.div_low;
      `TX_BUFFER_IDX:         rd_val = s.tx_buf[7:0];
      `IRQ_CONTROL_IDX:       rd_val = {4'h0, ~s.tx_full, s.rx_full,
                                        s.transmit_irq_enable, s.receive_irq_enable};
      default:                rd_val = 8'h00;
    endcase
    // Reading the receive buffer frees it already at the address phase
    if (addr_ok && !hwrite)
    begin
      n.rdata = {24'h000000, rd_val};
      if (haddr[4:2] == `RX_BUFFER_IDX)
        n.rx_full = 1'b0;
    end
    // Write data arrives one cycle after its address phase
    if (s.ph_valid && s.ph_write)
    begin
      case (s.ph_idx)
        `RX_STATUS_CONTROL_IDX:
        begin
          n.port_enable           = hwdata[`RX_PORT_ENABLE_BIT];
          n.nine_bit_rx_option    = hwdata[`RX_NINE_BIT_BIT];
          n.single_word_rx_enable = hwdata[`RX_SINGLE_BIT];
          n.continuous_rx_enable  = hwdata[`RX_CONTINUOUS_BIT];
          if (!hwdata[`RX_CONTINUOUS_BIT])
            n.overrun_error = 1'b0;
        end
        `TX_STATUS_CONTROL_IDX:
        begin
          n.clock_source_select = hwdata[`TX_CLOCK_SOURCE_BIT];
          n.nine_bit_tx_option  = hwdata[`TX_NINE_BIT_BIT];
          n.transmit_enable     = hwdata[`TX_ENABLE_BIT];
          n.sync_mode           = hwdata[`TX_SYNC_MODE_BIT];
          n.transmit_ninth_bit  = hwdata[`TX_NINTH_BIT];
        end
        `BAUD_CONTROL_IDX:
        begin
          n.clock_idle_polarity        = hwdata[`BAUD_POLARITY_BIT];
          n.sixteen_bit_divisor_option = hwdata[`BAUD_SIXTEEN_BIT];
        end
        `BAUD_DIV_HIGH_IDX: n.div_high = hwdata[7:0];
        `BAUD_DIV_LOW_IDX:  n.div_low  = hwdata[7:0];
        `IRQ_CONTROL_IDX:
        begin
          n.receive_irq_enable  = hwdata[`IRQ_RX_ENABLE_BIT];
          n.transmit_irq_enable = hwdata[`IRQ_TX_ENABLE_BIT];
        end
        default:
        begin
        end
      endcase
    end

    // ****************************************************************
    // Shift engine
    // ****************************************************************
    // Bit counter holds the bits already sampled in the current word
    cnt_inc = s.bit_cnt + 4'h1;
    nbits   = ((s.mode == SEND) ? s.nine_bit_tx_option : s.nine_bit_rx_option)
            ? `WORD_BITS_LONG : `WORD_BITS_SHORT;
    // Eight-bit words sit one place higher in the shift register
    word    = s.nine_bit_rx_option ? {s.dt_s2, s.receive_shift_register[8:1]}
                                   : {1'b0, s.dt_s2, s.receive_shift_register[8:2]};
    case (s.mode)
      IDLE:
      begin
        // Master waits for the clock to settle at idle before a new word
        // Half duplex: nothing new starts while a word is in flight
        if (enabled && (!master || (s.clk_lvl == s.clock_idle_polarity)))
        begin
          if (rx_go)
          begin
            // Receive enables win over a queued transmit word
            if (!s.overrun_error)
            begin
              n.mode    = RECV;
              n.bit_cnt = 4'h0;
            end
          end
          else if (s.transmit_enable && s.tx_full)
          begin
            n.mode                    = SEND;
            n.transmit_shift_register = s.tx_buf;
            n.dt_drive                = s.tx_buf[0];
            n.tx_full                 = 1'b0;
            n.bit_cnt                 = 4'h0;
            n.shift_owed              = 1'b0;
          end
        end
      end

      RECV:
      begin
        // Dropping an enable mid-word abandons the partial word
        if (!enabled || !rx_go)
          n.mode = IDLE;
        else if (fall)
        begin
          n.receive_shift_register = {s.dt_s2, s.receive_shift_register[8:1]};
          n.bit_cnt                = cnt_inc;
          if (cnt_inc == nbits)
          begin
            // word completes on the master or peer clock alone
            // Overrun drops the new word and keeps the unread one
            if (n.rx_full)
              n.overrun_error = 1'b1;
            else
            begin
              n.rx_buf             = word[7:0];
              n.received_ninth_bit = word[8];
              n.rx_full            = 1'b1;
            end
            if (master && !s.continuous_rx_enable)
              n.single_word_rx_enable = 1'b0;
            // Continuous reception re-enters RECV from IDLE for the next word
            n.mode = IDLE;
          end
        end
      end

      SEND:
      begin
        // Clearing the transmit enable abandons the word on the line
        if (!enabled || !s.transmit_enable)
          n.mode = IDLE;
        // Data moves on the rising edge so it is steady when the peer samples
        else if (rise && s.shift_owed)
        begin
          n.transmit_shift_register = {1'b0, s.transmit_shift_register[8:1]};
          n.dt_drive                = s.transmit_shift_register[1];
          n.shift_owed              = 1'b0;
        end
        else if (fall)
        begin
          // Count the bit the peer has just sampled
          n.bit_cnt    = cnt_inc;
          n.shift_owed = 1'b1;
          if (cnt_inc == nbits)
          begin
            if (s.tx_full)
            begin
              // Queued word follows back to back; flag rises only now
              n.transmit_shift_register = s.tx_buf;
              n.dt_drive                = s.tx_buf[0];
              n.tx_full                 = 1'b0;
              n.bit_cnt                 = 4'h0;
              n.shift_owed              = 1'b0;
            end
            else
              n.mode = IDLE;
          end
        end
      end
      // Unused encoding falls back to idle
      default: n.mode = IDLE;
    endcase

    // ****************************************************************
    // Transmit buffer write
    // ****************************************************************
    // Written after the engine so a new word is never lost to a same-cycle transfer
    if (s.ph_valid && s.ph_write && (s.ph_idx == `TX_BUFFER_IDX))
    begin
      n.tx_buf  = {s.transmit_ninth_bit, hwdata[7:0]};
      n.tx_full = 1'b1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Synchronous reset clears every field, so all pins start released
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= n;
  end

endmodule : sync_serial_receive_and_slave

// [verilog/sync_serial_regs.svh]
// Register offsets, field positions and reset values of the synchronous serial port
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH

// ****************************************************************
// Word indexes (byte address = 4 * index)
// ****************************************************************
`define RX_STATUS_CONTROL_IDX 3'h0
`define RX_BUFFER_IDX         3'h1
`define TX_STATUS_CONTROL_IDX 3'h2
`define BAUD_CONTROL_IDX      3'h3
`define BAUD_DIV_HIGH_IDX     3'h4
`define BAUD_DIV_LOW_IDX      3'h5
`define TX_BUFFER_IDX         3'h6
`define IRQ_CONTROL_IDX       3'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define RX_PORT_ENABLE_BIT    7
`define RX_NINE_BIT_BIT       6
`define RX_SINGLE_BIT         5
`define RX_CONTINUOUS_BIT     4
`define RX_FRAMING_BIT        2
`define RX_OVERRUN_BIT        1
`define RX_NINTH_BIT          0
`define TX_CLOCK_SOURCE_BIT   7
`define TX_NINE_BIT_BIT       6
`define TX_ENABLE_BIT         5
`define TX_SYNC_MODE_BIT      4
`define TX_SHIFT_EMPTY_BIT    1
`define TX_NINTH_BIT          0
`define BAUD_POLARITY_BIT     4
`define BAUD_SIXTEEN_BIT      3
`define IRQ_RX_ENABLE_BIT     0
`define IRQ_TX_ENABLE_BIT     1
`define IRQ_RX_FLAG_BIT       2
`define IRQ_TX_FLAG_BIT       3

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define CONTROL_RESET         8'h00
`define DIVISOR_RESET         8'h00
`define WORD_BITS_SHORT       4'h8
`define WORD_BITS_LONG        4'h9

`endif
